// ===== verilog/igd_pkg.sv
// Constants, field layouts and carrier types for the isolator gate drive
// control block.
// Assumes a 100 MHz clock and a plain register port with 32-bit data.
package igd_pkg;

  // Clock period used to turn times into cycle counts.
  localparam int CLK_PERIOD_NS = 10;

  // Filter and boost times in nanoseconds; least times, rounded up.
  localparam int PUMP_UV_FILTER_NS = 20000;
  localparam int GATE_UV_FILTER_NS = 20000;
  localparam int TURN_ON_BOOST_NS  = 8000;

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] PUMP_UV_FILTER_CYC =
    CNT_W'((PUMP_UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GATE_UV_FILTER_CYC =
    CNT_W'((GATE_UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TURN_ON_BOOST_CYC =
    CNT_W'((TURN_ON_BOOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Cycles the enable pin needs to read high again after a fault release.
  localparam logic [2:0] RELEASE_SETTLE_CYC = 3'h4;

  // Register map, byte offsets.
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] EVENT_OFS  = 4'h8;

  // Configuration fields and value after reset.
  localparam int CFG_PUMP_REPORT_BIT = 0;
  localparam int CFG_GATE_REPORT_BIT = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h3;

  // Sticky event fields.
  localparam int EVT_PUMP_BIT = 0;
  localparam int EVT_GATE_LSB = 1;
  localparam logic [3:0] EVENT_RESET = 4'h0;

  // Operating states of the drive sequencer.
  typedef enum {
    ST_SLEEP,
    ST_POWER_UP,
    ST_OFF,
    ST_BOOST,
    ST_HOLD
  } igd_state_t;

  // Pin inputs, carried together through the synchroniser.
  typedef struct packed {
    logic       enable;
    logic       belowFault;
    logic       ignition;
    logic       supplyOk;
    logic       pumpLow;
    logic       gateSupplyReady;
    logic [2:0] phaseLow;
  } igd_pins_t;

  localparam igd_pins_t PINS_RESET = 9'h000;

  // Status word, read in the low bits of the status register.
  typedef struct packed {
    logic [2:0] phaseUv;
    logic       pumpUv;
    logic       faultPull;
    logic       hold;
    logic       boost;
    logic       pumpOn;
    logic       sleep;
  } igd_status_t;

endpackage

// ===== verilog/igd_uv_filter.sv
// Undervoltage filter: one counter and one flag for a monitored voltage.
// Assumes a synchronised comparator level on the same clock.
`timescale 1ns/1ps
`default_nettype none
module igd_uv_filter #(
  parameter logic [igd_pkg::CNT_W-1:0] LIMIT = 12'h010
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic armed,
  input  wire logic below,
  output logic      uvFlag
);

  logic [igd_pkg::CNT_W-1:0] cnt_reg;
  logic [igd_pkg::CNT_W-1:0] cnt_next;
  logic                      flag_next;
  logic                      watching;
  logic                      expired;

  // The timer runs only while the monitor is armed and the level is low.
  assign watching  = armed & below;
  assign expired   = (cnt_reg == LIMIT - 12'h001);
  assign cnt_next  = (!watching) ? '0 :
                     (expired || uvFlag) ? cnt_reg :
                     cnt_reg + 12'h001;
  // The flag drops as soon as the level is back above threshold.
  assign flag_next = watching & (uvFlag | expired);

  // Counter and flag registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      uvFlag  <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      uvFlag  <= flag_next;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/igd_gate_ctrl.sv
// Control logic of a three-phase isolator gate driver with a shared
// open-drain enable terminal, activation inputs and undervoltage filters.
// Assumes asynchronous pins from the outside world, analog comparators that
// deliver logic levels, and a plain register port on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Enable high and both activations high: pump on, all drives on.
// - Enable driven low with both activations high: drives off, pump on.
// - Either activation low: pump off, drives off, enable ignored.
// - Pump disabled by activations means low-power sleep state.
// - Pumped supply low for the whole filter time sets pump fault.
// - Pump fault pulls enable to fault-low level, drive state unchanged.
// - Active phase gate low for filter time pulls enable, drives stay on.
// - Enable stays pulled until that phase's gate voltage recovers or the drives go off.
// - Enable pin encodes on, on with fault, and off states.
// - Enable rise gives a timed turn-on current, then hold current.
// - After power-up drives stay off until gate supply is sufficient.
module igd_gate_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       gateEnableIoIn,
  output logic                            gateEnableIoOut,
  output logic                            gateEnableIoOe,
  input  wire logic                       enableBelowFaultLevel,
  input  wire logic                       ignitionActivate,
  input  wire logic                       supplyOkActivate,
  input  wire logic                       pumpedSupplyLow,
  input  wire logic                       gateSupplyReady,
  input  wire logic [2:0]                 phaseGateLow,
  input  wire logic [igd_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]                regWrData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic [31:0]                     regRdData,
  output logic                            chargePumpEnable,
  output logic                            sleepMode,
  output logic [2:0]                      gateDriveOn,
  output logic [2:0]                      gateTurnOnCurrent,
  output logic [2:0]                      gateHoldCurrent
);

  igd_pkg::igd_pins_t  pinsRaw;
  igd_pkg::igd_pins_t  sync1_reg;
  igd_pkg::igd_pins_t  sync2_reg;
  igd_pkg::igd_pins_t  sync3_reg;
  igd_pkg::igd_pins_t  pins_reg;
  igd_pkg::igd_pins_t  pins_next;
  igd_pkg::igd_state_t state_reg;
  igd_pkg::igd_state_t state_next;
  igd_pkg::igd_status_t statusWord;

  logic [igd_pkg::CNT_W-1:0] boostCnt_reg;
  logic [igd_pkg::CNT_W-1:0] boostCnt_next;
  logic [2:0]  release_reg;
  logic [2:0]  release_next;
  logic [1:0]  config_reg;
  logic [1:0]  config_next;
  logic [3:0]  event_reg;
  logic [3:0]  event_next;
  logic [31:0] rdData_next;
  logic        faultPull_reg;
  logic        faultPull_next;

  logic        activated;
  logic        pumpActive;
  logic        driveActive;
  logic        boostDone;
  logic        faultMasking;
  logic        cmdOn;
  logic        pumpUvFlag;
  logic [2:0]  phaseGateUvFlag;
  logic        wrConfig;
  logic        wrEvent;
  logic        rdStatus;
  logic        rdConfig;
  logic        rdEvent;
  logic [3:0]  eventSet;
  logic [3:0]  eventClr;
  logic        pumpOnNext;
  logic        boostNext;
  logic        holdNext;

  // Gather the asynchronous pins into one word for the synchroniser.
  assign pinsRaw.enable          = gateEnableIoIn;
  assign pinsRaw.belowFault      = enableBelowFaultLevel;
  assign pinsRaw.ignition        = ignitionActivate;
  assign pinsRaw.supplyOk        = supplyOkActivate;
  assign pinsRaw.pumpLow         = pumpedSupplyLow;
  assign pinsRaw.gateSupplyReady = gateSupplyReady;
  assign pinsRaw.phaseLow        = phaseGateLow;

  // A pin change is accepted once the second and third stages agree.
  assign pins_next = ((sync2_reg ~^ sync3_reg) & sync3_reg) |
                     ((sync2_reg ^ sync3_reg) & pins_reg);

  // Three-stage synchroniser and agreement filter for all pins.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= igd_pkg::PINS_RESET;
      sync2_reg <= igd_pkg::PINS_RESET;
      sync3_reg <= igd_pkg::PINS_RESET;
      pins_reg  <= igd_pkg::PINS_RESET;
    end
    else
    begin
      sync1_reg <= pinsRaw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg  <= pins_next;
    end
  end

  // Both activation inputs must be high before the pump may run.
  assign activated   = pins_reg.ignition & pins_reg.supplyOk;
  assign pumpActive  = (state_reg != igd_pkg::ST_SLEEP);
  assign driveActive = state_reg inside {igd_pkg::ST_BOOST, igd_pkg::ST_HOLD};
  assign boostDone   = (boostCnt_reg == igd_pkg::TURN_ON_BOOST_CYC - 12'h001);

  // While this block pulls the pin, or the pin is still settling after a
  // release, a low pin is our own fault indication and not a command.
  // Only a level below the fault-low level is the controller's disable.
  assign faultMasking = faultPull_reg || (release_reg != 3'h0);
  assign cmdOn = pins_reg.enable ||
                 (faultMasking && driveActive &&
                  !pins_reg.belowFault);

  // Drive sequencer: sleep, power-up wait, off, turn-on boost, hold.
  always_comb
  begin
    state_next = state_reg;
    if (!activated)
    begin
      state_next = igd_pkg::ST_SLEEP;
    end
    else
    begin
      unique case (state_reg)
        igd_pkg::ST_SLEEP:
        begin
          state_next = igd_pkg::ST_POWER_UP;
        end
        igd_pkg::ST_POWER_UP:
        begin
          if (pins_reg.gateSupplyReady)
          begin
            state_next = igd_pkg::ST_OFF;
          end
        end
        igd_pkg::ST_OFF:
        begin
          if (cmdOn)
          begin
            state_next = igd_pkg::ST_BOOST;
          end
        end
        igd_pkg::ST_BOOST:
        begin
          if (!cmdOn)
          begin
            state_next = igd_pkg::ST_OFF;
          end
          else if (boostDone)
          begin
            state_next = igd_pkg::ST_HOLD;
          end
        end
        igd_pkg::ST_HOLD:
        begin
          if (!cmdOn)
          begin
            state_next = igd_pkg::ST_OFF;
          end
        end
      endcase
    end
  end

  // The boost timer runs only during the turn-on period.
  assign boostCnt_next = (state_reg != igd_pkg::ST_BOOST) ? '0 :
                         boostDone ? boostCnt_reg :
                         boostCnt_reg + 12'h001;

  // Sequencer state and boost timer.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= igd_pkg::ST_SLEEP;
      boostCnt_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      boostCnt_reg <= boostCnt_next;
    end
  end

  // The pump monitor watches whenever the pump runs.
  igd_uv_filter #(
    .LIMIT (igd_pkg::PUMP_UV_FILTER_CYC)
  ) u_pump_uv (
    .clk    (clk),
    .rst_n  (rst_n),
    .armed  (pumpActive),
    .below  (pins_reg.pumpLow),
    .uvFlag (pumpUvFlag)
  );

  // Each phase monitor watches only while the drives are on.
  generate
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_phase
      igd_uv_filter #(
        .LIMIT (igd_pkg::GATE_UV_FILTER_CYC)
      ) u_gate_uv (
        .clk    (clk),
        .rst_n  (rst_n),
        .armed  (driveActive),
        .below  (pins_reg.phaseLow[gi]),
        .uvFlag (phaseGateUvFlag[gi])
      );
    end
  endgenerate

  // Any reported fault pulls the pin; the drive state is left alone.
  assign faultPull_next =
    (pumpUvFlag && config_reg[igd_pkg::CFG_PUMP_REPORT_BIT]) ||
    ((|phaseGateUvFlag) &&
     config_reg[igd_pkg::CFG_GATE_REPORT_BIT]);

  // After a release the pin needs a few cycles to read high again.
  assign release_next = (faultPull_reg && !faultPull_next) ?
                        igd_pkg::RELEASE_SETTLE_CYC :
                        faultPull_next ? 3'h0 :
                        (release_reg != 3'h0) ? release_reg - 3'h1 :
                        3'h0;

  // Open-drain pull-down of the shared enable terminal.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      faultPull_reg   <= 1'b0;
      release_reg     <= 3'h0;
      gateEnableIoOe  <= 1'b0;
      gateEnableIoOut <= 1'b0;
    end
    else
    begin
      faultPull_reg   <= faultPull_next;
      release_reg     <= release_next;
      gateEnableIoOe  <= faultPull_next;
      gateEnableIoOut <= 1'b0;
    end
  end

  // Output levels follow the next state so each output is a flip-flop.
  assign pumpOnNext  = (state_next != igd_pkg::ST_SLEEP);
  assign boostNext   = (state_next == igd_pkg::ST_BOOST);
  assign holdNext    = (state_next == igd_pkg::ST_HOLD);

  // Pump, sleep and gate drive output registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chargePumpEnable  <= 1'b0;
      sleepMode         <= 1'b1;
      gateDriveOn       <= 3'h0;
      gateTurnOnCurrent <= 3'h0;
      gateHoldCurrent   <= 3'h0;
    end
    else
    begin
      chargePumpEnable  <= pumpOnNext;
      sleepMode         <= !pumpOnNext;
      gateDriveOn       <= {3{boostNext || holdNext}};
      gateTurnOnCurrent <= {3{boostNext}};
      gateHoldCurrent   <= {3{holdNext}};
    end
  end

  // Register port decode.
  assign wrConfig = regWrite && (regAddr == igd_pkg::CONFIG_OFS);
  assign wrEvent  = regWrite && (regAddr == igd_pkg::EVENT_OFS);
  assign rdStatus = regRead && (regAddr == igd_pkg::STATUS_OFS);
  assign rdConfig = regRead && (regAddr == igd_pkg::CONFIG_OFS);
  assign rdEvent  = regRead && (regAddr == igd_pkg::EVENT_OFS);

  // Report enables; writes change them, nothing else does.
  assign config_next = wrConfig ? regWrData[1:0] : config_reg;

  // Sticky events: write one to clear, a new event wins over the clear.
  assign eventSet = {phaseGateUvFlag, pumpUvFlag};
  assign eventClr = wrEvent ? regWrData[3:0] : 4'h0;
  assign event_next = (event_reg & ~eventClr) | eventSet;

  // Live status word.
  assign statusWord.phaseUv   = phaseGateUvFlag;
  assign statusWord.pumpUv    = pumpUvFlag;
  assign statusWord.faultPull = faultPull_reg;
  assign statusWord.hold      = (state_reg == igd_pkg::ST_HOLD);
  assign statusWord.boost     = (state_reg == igd_pkg::ST_BOOST);
  assign statusWord.pumpOn    = pumpActive;
  assign statusWord.sleep     = !pumpActive;

  // Read data stand for one cycle; unmapped addresses read as zero.
  assign rdData_next = rdStatus ? {23'h0, statusWord} :
                       rdConfig ? {30'h0, config_reg} :
                       rdEvent  ? {28'h0, event_reg} :
                       32'h00000000;

  // Register file and read data register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      config_reg <= igd_pkg::CONFIG_RESET;
      event_reg  <= igd_pkg::EVENT_RESET;
      regRdData  <= 32'h00000000;
    end
    else
    begin
      config_reg <= config_next;
      event_reg  <= event_next;
      regRdData  <= rdData_next;
    end
  end

endmodule
`default_nettype wire

// ===== verification/igd_gate_ctrl_sva.sv
// Checker for the gate drive control block; watches top ports only.
// Assumes one clock and the filter and boost counts of the package.
`timescale 1ns/1ps
`default_nettype none
module igd_gate_ctrl_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       gateEnableIoIn,
  input wire logic       gateEnableIoOut,
  input wire logic       gateEnableIoOe,
  input wire logic       enableBelowFaultLevel,
  input wire logic       ignitionActivate,
  input wire logic       supplyOkActivate,
  input wire logic       pumpedSupplyLow,
  input wire logic       gateSupplyReady,
  input wire logic [2:0] phaseGateLow,
  input wire logic       chargePumpEnable,
  input wire logic       sleepMode,
  input wire logic [2:0] gateDriveOn,
  input wire logic [2:0] gateTurnOnCurrent,
  input wire logic [2:0] gateHoldCurrent
);
  localparam int PF = int'(igd_pkg::PUMP_UV_FILTER_CYC);
  localparam int GF = int'(igd_pkg::GATE_UV_FILTER_CYC);
  localparam int BC = int'(igd_pkg::TURN_ON_BOOST_CYC);
  wire logic     pumpArm = pumpedSupplyLow && chargePumpEnable;
  wire logic     gateArm = (|phaseGateLow) && (|gateDriveOn);
  wire logic     act     = ignitionActivate && supplyOkActivate;
  logic [12:0]   pumpCnt_reg;
  logic [12:0]   gateCnt_reg;
  logic [12:0]   boostCnt_reg;

  // Run lengths of armed low levels and of the boost pulse.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pumpCnt_reg  <= 13'h0000;
      gateCnt_reg  <= 13'h0000;
      boostCnt_reg <= 13'h0000;
    end
    else
    begin
      pumpCnt_reg  <= pumpArm ? pumpCnt_reg + 13'h0001 : 13'h0000;
      gateCnt_reg  <= gateArm ? gateCnt_reg + 13'h0001 : 13'h0000;
      boostCnt_reg <= gateTurnOnCurrent[0] ? boostCnt_reg + 13'h0001
                                           : 13'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Steps of power-up and of a fault reported by the device.
  sequence pumpStartBare;
    $rose(chargePumpEnable) && !gateSupplyReady
      ##1 (!gateSupplyReady) [*6];
  endsequence
  sequence pulledByDevice;
    (gateEnableIoOe && !enableBelowFaultLevel) [*6];
  endsequence

  a_sleep_mirror: assert property (sleepMode == !chargePumpEnable)
    else $error("sleep flag differs from pump state");
  a_drives_alike: assert property (gateDriveOn inside {3'h0, 3'h7})
    else $error("phase drives disagree");
  a_open_drain: assert property (!gateEnableIoOut)
    else $error("enable pin driven high");
  a_idle_sleeps: assert property (!act [*8] |->
    !chargePumpEnable && gateDriveOn == 3'h0)
    else $error("active without both activations");
  a_enable_on: assert property ((gateEnableIoIn && !enableBelowFaultLevel
    && act && gateSupplyReady) [*8] |-> ##[0:4] gateDriveOn == 3'h7)
    else $error("drives not on while enabled");
  a_disable_off: assert property ((enableBelowFaultLevel && act) [*8]
    |-> gateDriveOn == 3'h0 && chargePumpEnable)
    else $error("drives not off under disable");
  a_boost_length: assert property ($fell(gateTurnOnCurrent[0]) &&
    gateHoldCurrent[0] |-> boostCnt_reg == 13'(BC))
    else $error("boost pulse length wrong");
  a_supply_wait: assert property (pumpStartBare |-> gateDriveOn == 3'h0)
    else $error("drives on before gate supply ready");
  a_no_early: assert property ($rose(gateEnableIoOe) |->
    pumpCnt_reg >= 13'(PF) || gateCnt_reg >= 13'(GF))
    else $error("fault pull before filter time");
  a_gate_pull: assert property (gateCnt_reg == 13'(GF + 12)
    |-> gateEnableIoOe)
    else $error("gate fault not reported");
  a_pump_pull: assert property (pumpCnt_reg == 13'(PF + 12)
    |-> gateEnableIoOe)
    else $error("pump fault not reported");
  a_drives_kept: assert property (pulledByDevice |=>
    $stable(gateDriveOn))
    else $error("fault pull changed drives");
  a_pull_release: assert property ($fell(|phaseGateLow) &&
    !pumpedSupplyLow |-> ##[1:10] !gateEnableIoOe)
    else $error("fault pull not released");
endmodule

bind igd_gate_ctrl igd_gate_ctrl_sva chk (
  .clk                   (clk),
  .rst_n                 (rst_n),
  .gateEnableIoIn        (gateEnableIoIn),
  .gateEnableIoOut       (gateEnableIoOut),
  .gateEnableIoOe        (gateEnableIoOe),
  .enableBelowFaultLevel (enableBelowFaultLevel),
  .ignitionActivate      (ignitionActivate),
  .supplyOkActivate      (supplyOkActivate),
  .pumpedSupplyLow       (pumpedSupplyLow),
  .gateSupplyReady       (gateSupplyReady),
  .phaseGateLow          (phaseGateLow),
  .chargePumpEnable      (chargePumpEnable),
  .sleepMode             (sleepMode),
  .gateDriveOn           (gateDriveOn),
  .gateTurnOnCurrent     (gateTurnOnCurrent),
  .gateHoldCurrent       (gateHoldCurrent)
);
`default_nettype wire

// ===== verification/igd_ctrl_model.sv
// Controller on the shared enable pin: open-drain pull-down, pull-up.
// Assumes the device only pulls the pin while its output enable is high.
`timescale 1ns/1ps
`default_nettype none
module igd_ctrl_model (
  input  wire logic disableReq,
  input  wire logic devOe,
  output logic      pinLevel,
  output logic      belowFault,
  output logic      faultSeen
);
  // Either party pulls the pin low, otherwise the resistor lifts it.
  assign pinLevel   = !(disableReq || devOe);
  // Our own pull-down goes lower than the device's fault level.
  assign belowFault = disableReq;
  // A low level we did not cause is taken as a fault.
  assign faultSeen  = !pinLevel && !disableReq;
endmodule
`default_nettype wire

// ===== verification/igd_gate_ctrl_bench.sv
// Bench for the gate drive control block and its controller model.
// Assumes the package counts and the block's register map.
`timescale 1ns/1ps
`default_nettype none
module igd_gate_ctrl_bench;
  localparam int PF = int'(igd_pkg::PUMP_UV_FILTER_CYC);
  localparam int GF = int'(igd_pkg::GATE_UV_FILTER_CYC);
  localparam int BC = int'(igd_pkg::TURN_ON_BOOST_CYC);
  logic        clk, rst_n, ign, supply_ok_activate, pumpLow, ready, disReq;
  logic        pin, below, oe, odOut, faultSeen, pumpOn, sleep;
  logic        regWrite, regRead;
  logic [2:0]  phaseLow, drv, boost, hold;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, rdData;
  int          errCount, nChecks;

  igd_gate_ctrl DUT (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .gateEnableIoIn        (pin),
    .gateEnableIoOut       (odOut),
    .gateEnableIoOe        (oe),
    .enableBelowFaultLevel (below),
    .ignitionActivate      (ign),
    .supplyOkActivate      (supply_ok_activate),
    .pumpedSupplyLow       (pumpLow),
    .gateSupplyReady       (ready),
    .phaseGateLow          (phaseLow),
    .regAddr               (regAddr),
    .regWrData             (regWrData),
    .regWrite              (regWrite),
    .regRead               (regRead),
    .regRdData             (rdData),
    .chargePumpEnable      (pumpOn),
    .sleepMode             (sleep),
    .gateDriveOn           (drv),
    .gateTurnOnCurrent     (boost),
    .gateHoldCurrent       (hold)
  );

  igd_ctrl_model ctrl (
    .disableReq (disReq),
    .devOe      (oe),
    .pinLevel   (pin),
    .belowFault (below),
    .faultSeen  (faultSeen)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle read strobe; data is looked at in the following cycle.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 7000 cycles.
  initial
  begin
    wt(20000);
    errCount++;
    wrapUp();
  end

  // Main sequence.
  initial
  begin
    {rst_n, ign, supply_ok_activate, pumpLow, ready, disReq} = 6'h00;
    {regWrite, regRead, phaseLow, regAddr, regWrData} = 41'h0;
    wt(16);
    rst_n <= 1'b1;
    wt(6);
    rd(4'h0, 32'h001);
    rd(4'h4, 32'h003);
    rd(4'hC, 32'h000);
    wr(4'h4, 32'h000);
    rd(4'h4, 32'h000);
    wr(4'h4, 32'h003);
    rd(4'h4, 32'h003);
    for (int k = 0; k < 3; k++)
    begin
      wt(1);
      ign <= k[0];
      supply_ok_activate <= k[1];
      wt(12);
      #1;
      chk(32'({pumpOn, sleep, drv}), 32'h08);
    end
    $display("test sleep done");
    wt(1);
    ign <= 1'b1;
    supply_ok_activate <= 1'b1;
    wt(12);
    #1;
    chk(32'({pumpOn, sleep, drv}), 32'h10);
    wt(1);
    ready <= 1'b1;
    wt(12);
    #1;
    chk(32'({drv, boost}), 32'h3F);
    wt(BC);
    #1;
    chk(32'({drv, boost, hold}), 32'h1C7);
    $display("test power up done");
    wt(1);
    disReq <= 1'b1;
    wt(12);
    #1;
    chk(32'({faultSeen, pumpOn, drv}), 32'h08);
    wt(1);
    disReq <= 1'b0;
    wt(BC + 20);
    #1;
    chk(32'({drv, hold}), 32'h3F);
    $display("test disable done");
    wt(1);
    phaseLow <= 3'h2;
    wt(GF / 2);
    phaseLow <= 3'h0;
    wt(12);
    #1;
    chk(32'(oe), 32'h0);
    rd(4'h8, 32'h0);
    wt(1);
    phaseLow <= 3'h2;
    wt(GF + 12);
    #1;
    chk(32'({oe, pin, faultSeen, drv}), 32'h2F);
    rd(4'h0, 32'h09A);
    wt(1);
    phaseLow <= 3'h0;
    wt(12);
    #1;
    chk(32'(oe), 32'h0);
    rd(4'h8, 32'h004);
    wr(4'h8, 32'h004);
    rd(4'h8, 32'h000);
    $display("test gate fault done");
    wt(1);
    pumpLow <= 1'b1;
    wt(PF + 12);
    #1;
    chk(32'({oe, drv}), 32'hF);
    wt(1);
    disReq <= 1'b1;
    wt(12);
    #1;
    chk(32'({oe, pumpOn, drv}), 32'h18);
    rd(4'h0, 32'h032);
    rd(4'h8, 32'h001);
    wt(1);
    pumpLow <= 1'b0;
    wt(12);
    disReq <= 1'b0;
    wt(12);
    #1;
    chk(32'({oe, drv}), 32'h7);
    $display("test pump fault done");
    wt(1);
    ign <= 1'b0;
    wt(12);
    #1;
    chk(32'({pumpOn, sleep, drv}), 32'h08);
    $display("test shutdown done");
    wrapUp();
  end
endmodule
`default_nettype wire
